// ===== logic/acs_pkg.sv
// Purpose: Shared constants for the converter sequencer.
// Assumes: One 8-bit register port, clock at 2 MHz.
// Notes: Sequence timing is counted in sequencer clock cycles.
package acs_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h30;
   localparam logic [7:0] ADDR_RESULT_1 = 8'h31;
   localparam logic [7:0] ADDR_RESULT_2 = 8'h32;
   localparam logic [7:0] ADDR_RESULT_3 = 8'h33;
   localparam logic [7:0] ADDR_RESULT_4 = 8'h34;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h35;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h36;
   localparam logic [7:0] ADDR_LOW_POWER_CFG = 8'h37;

   // ==========================================================
   // Control, configuration and interrupt field positions
   localparam int CTL_DONE_BIT = 7;
   localparam int CTL_SCAN_BIT = 5;
   localparam int CTL_MULTI_CHANNEL_SEL_BIT = 4;
   localparam int CTL_CHAN_LSB = 0;
   localparam int CFG_DELAY_BIT = 0;
   localparam int IRQ_SEQ_DONE_BIT = 0;
   localparam int IRQ_RESULT_BIT = 1;

   // ==========================================================
   // Reset values
   localparam logic [5:0] CONTROL_RESET = 6'h00;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   localparam logic CFG_DELAY_RESET = 1'b1;

   // ==========================================================
   // Timing
   localparam int PASS_TIME_NS = 64000;
   localparam int E_CLOCK_KHZ = 2000;
   localparam int CONVS_PER_PASS = 4;
   localparam int PASS_CYCLES = PASS_TIME_NS * E_CLOCK_KHZ / 1000000;
   localparam int CONV_CYCLES = PASS_CYCLES / CONVS_PER_PASS;
   localparam logic [4:0] CONV_LAST = 5'(CONV_CYCLES - 1);
   localparam int STARTUP_CYCLES = 4000;
   localparam logic [11:0] STARTUP_LAST = 12'(STARTUP_CYCLES - 1);

   // ==========================================================
   // Channel codes
   localparam logic [3:0] CODE_REF_HIGH = 4'hC;
   localparam logic [3:0] CODE_REF_LOW = 4'hD;
   localparam logic [3:0] CODE_REF_HALF = 4'hE;

   typedef enum logic [1:0] {
      ACS_IDLE = 2'b00,
      ACS_CONVERT = 2'b01,
      ACS_SUSPEND = 2'b10,
      ACS_SETTLE = 2'b11
   } acs_state_t;

endpackage

// ===== logic/acs_result_mem.sv
// Purpose: Four 8-bit result words with a registered read port.
// Assumes: Write and read in the same cycle may target one word.
// Notes: Read data stand in the cycle after each read enable, then return to zero.
`timescale 1ns/100ps
module acs_result_mem (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic wr_en_in,
   input wire logic [1:0] wr_idx_in,
   input wire logic [7:0] wr_data_in,
   input wire logic rd_en_in,
   input wire logic rd_mem_in,
   input wire logic [1:0] rd_idx_in,
   input wire logic [7:0] rd_alt_in,
   output logic [7:0] rd_data_out
);

   logic [7:0] words [4];

   // ==========================================================
   // Storage
   // The words keep no reset: their content is undefined until the
   // first sequence has filled them.
   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         words[wr_idx_in] <= wr_data_in;
      end
   end

   // ==========================================================
   // Read port
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_data_out <= 8'h00;
      end else if (rd_en_in) begin
         rd_data_out <= rd_mem_in ? words[rd_idx_in] : rd_alt_in;
      end else begin
         rd_data_out <= 8'h00;
      end
   end

endmodule

// ===== logic/acs_sequencer.sv
// Purpose: Conversion sequencer of an 8-bit analog-to-digital converter.
// Assumes: The analog converter sits outside; its result bus is stable
// for several cycles before the end of each conversion slot.
// Notes: Stop and wait requests arrive from outside the clock domain.
//
// Behaviour
// RULE1: Scan clear converts once; set repeats forever.
// RULE2: Single mode converts one channel four times.
// RULE3: Multi mode converts four channels, one register each.
// RULE4: Multi mode ignores two low select bits.
// RULE5: Codes 0 to 7 select analog inputs.
// RULE6: Codes 12-14 select references; others reserved.
// RULE7: Result registers are read only.
// RULE8: Software trusts results once done flag set.
// RULE9: Low power suspends; resume resamples current channel.
// RULE10: After wait exit, first conversion is valid.
// RULE11: Stop exit with delay settles before converting; a control write cuts the settle short, and a stop ending while idle gets none.
// RULE12: Without delay, software waits 10 ms.
// RULE13: Full four-conversion pass takes 64 us.
// RULE14: Control write clears flag, restarts sequence.
// RULE15: Flag sets when four results are stored.
// RULE16: Fifth conversion overwrites result one, cyclically.
// RULE17: Each conversion lasts 32 cycles.
// RULE18: Results written strictly to registers one to four.
`timescale 1ns/100ps
module acs_sequencer (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic [7:0] conv_data_in,
   input wire logic stop_mode_in,
   input wire logic wait_mode_in,
   output logic conv_sample_out,
   output logic [7:0] analog_sel_out,
   output logic [2:0] ref_sel_out,
   output logic analog_bias_en_out,
   output logic busy_out,
   output logic irq_out
);

   // ==========================================================
   // Channel decode
   // One-hot analog input select; reserved codes select nothing.
   function automatic logic [7:0] input_select(input logic [3:0] code);
      input_select = 8'h00;
      if (!code[3]) begin
         input_select[code[2:0]] = 1'b1;
      end
   endfunction

   // Reference select: bit 0 high, bit 1 low, bit 2 half of high.
   function automatic logic [2:0] ref_select(input logic [3:0] code);
      logic [2:0] sel;
      sel = 3'h0;
      unique case (code)
         acs_pkg::CODE_REF_HIGH: sel = 3'h1;
         acs_pkg::CODE_REF_LOW: sel = 3'h2;
         acs_pkg::CODE_REF_HALF: sel = 3'h4;
         default: sel = 3'h0;
      endcase
      ref_select = sel;
   endfunction

   // Code converted in a slot: group mode puts the slot number in the
   // two low select bits.
   function automatic logic [3:0] slot_select(input logic multi,
      input logic [3:0] chan, input logic [1:0] idx);
      slot_select = multi ? {chan[3:2], idx} // RULE3 RULE4
                          : chan; // RULE2
   endfunction

   // ==========================================================
   // Declarations
   acs_pkg::acs_state_t state;
   acs_pkg::acs_state_t next_state;
   logic scan;
   logic multi_channel_sel;
   logic [3:0] chan_code;
   logic done_flag;
   logic [1:0] slot;
   logic [4:0] conv_cnt;
   logic [11:0] settle_cnt;
   logic exit_delay;
   logic left_by_stop;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic [7:0] data_meta;
   logic [7:0] data_sync;
   logic stop_meta;
   logic stop_sync;
   logic wait_meta;
   logic wait_sync;

   // ==========================================================
   // Synchronisers
   // Each data bit is synchronised on its own; the converter holds its
   // result steady for several cycles before the slot ends, so bits
   // that settle on different edges are never stored as a mixed word.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         data_meta <= 8'h00;
         data_sync <= 8'h00;
         stop_meta <= 1'b0;
         stop_sync <= 1'b0;
         wait_meta <= 1'b0;
         wait_sync <= 1'b0;
      end else begin
         data_meta <= conv_data_in;
         data_sync <= data_meta;
         stop_meta <= stop_mode_in;
         stop_sync <= stop_meta;
         wait_meta <= wait_mode_in;
         wait_sync <= wait_meta;
      end
   end

   // ==========================================================
   // Register decode
   wire ctl_write = wr_in && (addr_in == acs_pkg::ADDR_CONTROL_STATUS);
   wire sts_write = wr_in && (addr_in == acs_pkg::ADDR_IRQ_STATUS);
   wire msk_write = wr_in && (addr_in == acs_pkg::ADDR_IRQ_MASK);
   wire cfg_write = wr_in && (addr_in == acs_pkg::ADDR_LOW_POWER_CFG);
   // Result addresses decode for reads only, so writes there vanish.
   wire rd_result = (addr_in >= acs_pkg::ADDR_RESULT_1) &&
                    (addr_in <= acs_pkg::ADDR_RESULT_4); // RULE7
   // Only the two low bits of the offset matter once the range check
   // above has passed.
   wire [1:0] rd_idx = 2'(addr_in - acs_pkg::ADDR_RESULT_1);
   wire low_power = stop_sync || wait_sync;

   wire [7:0] ctl_read = {done_flag, 1'b0, scan, multi_channel_sel, chan_code};
   wire [7:0] alt_read =
      (addr_in == acs_pkg::ADDR_CONTROL_STATUS) ? ctl_read :
      (addr_in == acs_pkg::ADDR_IRQ_STATUS) ? {6'h00, irq_status} :
      (addr_in == acs_pkg::ADDR_IRQ_MASK) ? {6'h00, irq_mask} :
      (addr_in == acs_pkg::ADDR_LOW_POWER_CFG) ? {7'h00, exit_delay} :
      8'h00;

   // ==========================================================
   // Slot timing and the channel of the next slot
   wire conv_end = (state == acs_pkg::ACS_CONVERT) &&
                   (conv_cnt == acs_pkg::CONV_LAST) && !low_power; // RULE17
   wire pass_end = conv_end && (slot == 2'h3);
   wire settle_end = (settle_cnt == acs_pkg::STARTUP_LAST);
   // The select outputs are registered, so they are fed from the slot
   // and control values that take effect at the same edge; otherwise a
   // new slot would open with the select of the slot before it.
   wire [1:0] next_slot = ctl_write ? 2'h0 :
                          conv_end ? 2'(slot + 2'h1) : slot;
   wire next_multi_channel_sel = ctl_write ? wdata_in[acs_pkg::CTL_MULTI_CHANNEL_SEL_BIT] : multi_channel_sel;
   wire [3:0] next_chan =
      ctl_write ? wdata_in[acs_pkg::CTL_CHAN_LSB +: 4] : chan_code;
   wire [3:0] slot_code = slot_select(next_multi_channel_sel, next_chan, next_slot);

   // ==========================================================
   // Sequencer state
   always_comb begin
      next_state = state;
      unique case (state)
         acs_pkg::ACS_IDLE: begin
            next_state = acs_pkg::ACS_IDLE;
         end
         acs_pkg::ACS_CONVERT: begin
            if (low_power) begin
               next_state = acs_pkg::ACS_SUSPEND; // RULE9
            end else if (pass_end && !scan) begin
               next_state = acs_pkg::ACS_IDLE; // RULE1
            end
         end
         acs_pkg::ACS_SUSPEND: begin
            if (!low_power) begin
               if (left_by_stop && exit_delay) begin
                  next_state = acs_pkg::ACS_SETTLE; // RULE11
               end else begin
                  next_state = acs_pkg::ACS_CONVERT; // RULE10
               end
            end
         end
         acs_pkg::ACS_SETTLE: begin
            if (low_power) begin
               next_state = acs_pkg::ACS_SUSPEND;
            end else if (settle_end) begin
               next_state = acs_pkg::ACS_CONVERT;
            end
         end
      endcase
      if (ctl_write) begin
         next_state = low_power ? acs_pkg::ACS_SUSPEND
                                : acs_pkg::ACS_CONVERT; // RULE14
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= acs_pkg::ACS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // Slot and cycle counters
   // Leaving the convert state always clears the cycle count, so a
   // suspended channel is sampled afresh on return.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         conv_cnt <= 5'h00;
         slot <= 2'h0;
      end else if (ctl_write) begin
         conv_cnt <= 5'h00;
         slot <= 2'h0; // RULE14
      end else if (state != acs_pkg::ACS_CONVERT || low_power) begin
         conv_cnt <= 5'h00; // RULE9
      end else if (conv_end) begin
         conv_cnt <= 5'h00;
         slot <= 2'(slot + 2'h1); // RULE16 RULE18
      end else begin
         conv_cnt <= 5'(conv_cnt + 5'h01); // RULE13
      end
   end

   // The settle wait is fixed; software that turns it off must wait for
   // the converter itself, since nothing here holds results back.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         settle_cnt <= 12'h000;
      end else if (state == acs_pkg::ACS_SETTLE) begin
         settle_cnt <= 12'(settle_cnt + 12'h001);
      end else begin
         settle_cnt <= 12'h000;
      end
   end

   // Only a stop turns the bias off, so only a stop exit may need the
   // settle wait; a wait that overlaps a stop still counts as a stop.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         left_by_stop <= 1'b0;
      end else if (state != acs_pkg::ACS_SUSPEND && low_power) begin
         left_by_stop <= stop_sync;
      end else if (state == acs_pkg::ACS_SUSPEND && stop_sync) begin
         left_by_stop <= 1'b1;
      end
   end

   // ==========================================================
   // Control, configuration and done flag
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         scan <= acs_pkg::CONTROL_RESET[acs_pkg::CTL_SCAN_BIT];
         multi_channel_sel <= acs_pkg::CONTROL_RESET[acs_pkg::CTL_MULTI_CHANNEL_SEL_BIT];
         chan_code <= acs_pkg::CONTROL_RESET[3:0];
         exit_delay <= acs_pkg::CFG_DELAY_RESET;
      end else begin
         if (ctl_write) begin
            scan <= wdata_in[acs_pkg::CTL_SCAN_BIT];
            multi_channel_sel <= wdata_in[acs_pkg::CTL_MULTI_CHANNEL_SEL_BIT];
            chan_code <= wdata_in[acs_pkg::CTL_CHAN_LSB +: 4];
         end
         if (cfg_write) begin
            exit_delay <= wdata_in[acs_pkg::CFG_DELAY_BIT];
         end
      end
   end

   // A new command abandons the running pass, so its own clear wins
   // over a pass that ends in the same cycle.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         done_flag <= 1'b0;
      end else if (ctl_write) begin
         done_flag <= 1'b0; // RULE14
      end else if (pass_end) begin
         done_flag <= 1'b1; // RULE15 RULE8
      end
   end

   // ==========================================================
   // Interrupts
   // An event and a clear in the same cycle leave the bit set, so an
   // event is never lost to a clear aimed at an older one.
   wire [1:0] irq_events;
   assign irq_events[acs_pkg::IRQ_SEQ_DONE_BIT] = pass_end; // RULE15
   assign irq_events[acs_pkg::IRQ_RESULT_BIT] = conv_end;
   wire [1:0] irq_clear = sts_write ? wdata_in[1:0] : 2'h0;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         irq_status <= acs_pkg::IRQ_RESET;
         irq_mask <= acs_pkg::IRQ_RESET;
         irq_out <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | irq_events;
         if (msk_write) begin
            irq_mask <= wdata_in[1:0];
         end
         irq_out <= |(irq_status & irq_mask);
      end
   end

   // ==========================================================
   // Analog side outputs
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         conv_sample_out <= 1'b0;
         analog_sel_out <= 8'h00;
         ref_sel_out <= 3'h0;
         analog_bias_en_out <= 1'b0;
         busy_out <= 1'b0;
      end else begin
         // A slot opens on each entry into converting and at each slot
         // boundary; a control write reopens slot zero even mid-slot.
         conv_sample_out <= (next_state == acs_pkg::ACS_CONVERT) &&
                            (state != acs_pkg::ACS_CONVERT || conv_end ||
                             ctl_write);
         analog_sel_out <= input_select(slot_code); // RULE5
         ref_sel_out <= ref_select(slot_code); // RULE6
         analog_bias_en_out <= !stop_sync;
         busy_out <= (next_state != acs_pkg::ACS_IDLE);
      end
   end

   // ==========================================================
   // Result storage and read port
   acs_result_mem u_results (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .wr_en_in(conv_end),
      .wr_idx_in(slot), // RULE18
      .wr_data_in(data_sync),
      .rd_en_in(rd_in),
      .rd_mem_in(rd_result),
      .rd_idx_in(rd_idx),
      .rd_alt_in(alt_read),
      .rd_data_out(rdata_out)
   );

endmodule

// ===== tb/acs_sequencer_assertions.sv
// Purpose: Port-level timing and selection checks for the sequencer.
// Assumes: Sees only the sequencer ports.
// Notes: Slot length is only judged between two undisturbed slots.
`timescale 1ns/100ps
module acs_sequencer_chk (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic stop_mode_in,
   input wire logic wait_mode_in,
   input wire logic conv_sample_out,
   input wire logic [7:0] analog_sel_out,
   input wire logic [2:0] ref_sel_out,
   input wire logic analog_bias_en_out,
   input wire logic busy_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // ==========================================================
   // Helper state
   wire cw = wr_in && addr_in == acs_pkg::ADDR_CONTROL_STATUS;
   wire lp = stop_mode_in | wait_mode_in;
   logic [7:0] ctl;
   logic [7:0] gap;
   logic clean;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctl <= 8'h00;
         gap <= 8'h00;
         clean <= 1'b0;
      end else begin
         if (cw) ctl <= wdata_in;
         gap <= conv_sample_out ? 8'h01 : gap + 8'h01;
         // A control write or low power spoils the next gap measurement.
         clean <= !lp && !cw && (conv_sample_out || clean);
      end
   end
   // ==========================================================
   // Properties
   property p_start;
      cw && !lp |=> conv_sample_out && busy_out;
   endproperty
   a_start: assert property (p_start)
      else $error("no slot start after control write");
   property p_slot;
      conv_sample_out && clean |-> gap == 8'h20;
   endproperty
   a_slot: assert property (p_slot)
      else $error("slot length wrong");
   property p_single;
      conv_sample_out && !ctl[4] && !ctl[3]
      |-> analog_sel_out == 8'h01 << ctl[2:0] && ref_sel_out == 3'h0;
   endproperty
   a_single: assert property (p_single)
      else $error("single channel select wrong");
   property p_multi;
      conv_sample_out && ctl[4] && !ctl[3]
      |-> $onehot(analog_sel_out)
      && (analog_sel_out & (ctl[2] ? 8'h0F : 8'hF0)) == 8'h00;
   endproperty
   a_multi: assert property (p_multi)
      else $error("multi group select wrong");
   property p_ref;
      conv_sample_out && !ctl[4] && ctl[3:2] == 2'h3
      |-> analog_sel_out == 8'h00
      && ref_sel_out == (ctl[1:0] == 2'h3 ? 3'h0 : 3'h1 << ctl[1:0]);
   endproperty
   a_ref: assert property (p_ref)
      else $error("reference select wrong");
   property p_rsvd;
      conv_sample_out && ctl[3:2] == 2'h2
      |-> analog_sel_out == 8'h00 && ref_sel_out == 3'h0;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved code drives a select");
   property p_idle;
      !busy_out && !cw |=> !conv_sample_out;
   endproperty
   a_idle: assert property (p_idle)
      else $error("slot start while idle");
   property p_susp;
      wait_mode_in [*4] |-> !conv_sample_out;
   endproperty
   a_susp: assert property (p_susp)
      else $error("slot start during wait");
   property p_hold;
      busy_out && lp |=> busy_out;
   endproperty
   a_hold: assert property (p_hold)
      else $error("sequence lost in low power");
   property p_bias;
      stop_mode_in [*4] |-> !analog_bias_en_out;
   endproperty
   a_bias: assert property (p_bias)
      else $error("bias on during stop");
endmodule

// ===== tb/tb_acs_sequencer.sv
// Purpose: Self-checking bench for the conversion sequencer.
// Assumes: Converter data is driven by the bench per slot.
// Notes: Uses the full 4000-cycle stop settle.
`timescale 1ns/100ps
module tb_acs_sequencer;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [7:0] conv_data_in = 8'h00;
   logic stop_mode_in = 1'b0;
   logic wait_mode_in = 1'b0;
   logic [7:0] rdata_out;
   logic conv_sample_out;
   logic [7:0] analog_sel_out;
   logic [2:0] ref_sel_out;
   logic analog_bias_en_out;
   logic busy_out;
   logic irq_out;
   int err_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int tp;
   always #12.5 clk_in = ~clk_in;
   always @(posedge clk_in) cyc <= cyc + 1;
   acs_sequencer i_acs_sequencer (.clk_in(clk_in), .rstn_in(rstn_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
      .rd_in(rd_in), .rdata_out(rdata_out), .conv_data_in(conv_data_in),
      .stop_mode_in(stop_mode_in), .wait_mode_in(wait_mode_in),
      .conv_sample_out(conv_sample_out), .analog_sel_out(analog_sel_out),
      .ref_sel_out(ref_sel_out), .analog_bias_en_out(analog_bias_en_out),
      .busy_out(busy_out), .irq_out(irq_out));
   // ==========================================================
   // Shared tasks
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rdata_out});
   endtask
   task automatic smp();
      for (int i = 0; i < 300; i++) begin
         @(posedge clk_in);
         if (conv_sample_out === 1'b1) return;
      end
      chk("slot start", 16'h1, 16'h0);
   endtask
   task automatic idle();
      for (int i = 0; i < 6000; i++) begin
         @(posedge clk_in);
         if (busy_out === 1'b0) return;
      end
      chk("idle", 16'h0, 16'h1);
   endtask
   function automatic logic [15:0] exp_sel(logic [7:0] w, int k);
      logic [3:0] c;
      c = w[4] ? {w[3:2], 2'(k)} : w[3:0];
      if (!c[3]) return {8'h00, 8'h01 << c[2:0]};
      if (c[2] && c[1:0] != 2'h3) return {5'h00, 3'h1 << c[1:0], 8'h00};
      return 16'h0000;
   endfunction
   // Runs one pass; scanning passes return after the fourth slot start.
   task automatic pass(logic [7:0] w, logic [31:0] v);
      int t0;
      wr(8'h30, w);
      t0 = cyc;
      for (int k = 0; k < 4; k++) begin
         smp();
         conv_data_in <= v[8*k +: 8];
         chk("select", exp_sel(w, k), {5'h00, ref_sel_out, analog_sel_out});
      end
      if (!w[5]) idle();
      tp = cyc - t0;
   endtask
   task automatic res(logic [31:0] v);
      for (int k = 0; k < 4; k++)
         rd(8'h31 + 8'(k), v[8*k +: 8]);
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      rd(8'h30, 8'h00);
      rd(8'h36, 8'h00);
      rd(8'h37, 8'h01);
      rd(8'h3F, 8'h00);
      wr(8'h30, 8'h40);
      rd(8'h30, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_once();
      pass(8'h05, 32'hC3A55A3C);
      chk("pass time", 16'h1, {15'h0, tp >= 128 && tp <= 132});
      rd(8'h30, 8'h85);
      res(32'hC3A55A3C);
      wr(8'h31, 8'hFF);
      rd(8'h31, 8'h3C);
      rd(8'h35, 8'h03);
      $display("single test done");
   endtask
   task automatic t_multi();
      pass(8'h17, 32'h44332211);
      res(32'h44332211);
      pass(8'h1E, 32'h0F0E0D0C);
      pass(8'h18, 32'h08080808);
      $display("multi test done");
   endtask
   task automatic t_codes();
      logic [7:0] w[6] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h08, 8'h0B};
      foreach (w[i]) begin
         wr(8'h30, w[i]);
         smp();
         chk("code", exp_sel(w[i], 0), {5'h00, ref_sel_out, analog_sel_out});
      end
      idle();
      $display("code test done");
   endtask
   task automatic t_scan();
      pass(8'h32, 32'h04030201);
      smp();
      conv_data_in <= 8'h99;
      smp();
      rd(8'h30, 8'hB2);
      rd(8'h31, 8'h99);
      rd(8'h32, 8'h02);
      chk("busy", 16'h1, {15'h0, busy_out});
      wr(8'h30, 8'h32);
      rd(8'h30, 8'h32);
      wr(8'h30, 8'h02);
      idle();
      $display("scan test done");
   endtask
   task automatic t_irq();
      wr(8'h35, 8'h03);
      wr(8'h36, 8'h01);
      rd(8'h36, 8'h01);
      chk("irq", 16'h0, {15'h0, irq_out});
      pass(8'h01, 32'h01010101);
      @(posedge clk_in);
      chk("irq", 16'h1, {15'h0, irq_out});
      wr(8'h35, 8'h01);
      repeat (2) @(posedge clk_in);
      chk("irq", 16'h0, {15'h0, irq_out});
      $display("irq test done");
   endtask
   task automatic t_lp();
      int t0;
      wr(8'h30, 8'h03);
      smp();
      conv_data_in <= 8'h5A;
      smp();
      conv_data_in <= 8'h66;
      repeat (10) @(posedge clk_in);
      wait_mode_in <= 1'b1;
      conv_data_in <= 8'hA7;
      repeat (20) @(posedge clk_in);
      wait_mode_in <= 1'b0;
      idle();
      res(32'hA7A7A75A);
      wr(8'h30, 8'h03);
      smp();
      conv_data_in <= 8'h3C;
      repeat (5) @(posedge clk_in);
      stop_mode_in <= 1'b1;
      repeat (20) @(posedge clk_in);
      chk("bias", 16'h0, {15'h0, analog_bias_en_out});
      stop_mode_in <= 1'b0;
      t0 = cyc;
      idle();
      chk("settle", 16'h1, {15'h0, cyc - t0 > 4000});
      res(32'h3C3C3C3C);
      wr(8'h37, 8'h00);
      wr(8'h30, 8'h13);
      smp();
      stop_mode_in <= 1'b1;
      repeat (20) @(posedge clk_in);
      stop_mode_in <= 1'b0;
      t0 = cyc;
      smp();
      chk("no settle", 16'h1, {15'h0, cyc - t0 < 10});
      idle();
      rd(8'h30, 8'h93);
      $display("low power test done");
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_in);
      err_count++;
      end_of_test();
   end
   initial begin
      repeat (6) @(posedge clk_in);
      rstn_in <= 1'b1;
      t_reset();
      t_once();
      t_multi();
      t_codes();
      t_scan();
      t_irq();
      t_lp();
      end_of_test();
   end
endmodule
bind acs_sequencer acs_sequencer_chk i_acs_sequencer_chk (
   .clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .stop_mode_in(stop_mode_in),
   .wait_mode_in(wait_mode_in), .conv_sample_out(conv_sample_out),
   .analog_sel_out(analog_sel_out), .ref_sel_out(ref_sel_out),
   .analog_bias_en_out(analog_bias_en_out), .busy_out(busy_out));
